// >>> hw/pbc_regs.sv
// basic phy control register and status capability bits
`timescale 1ns/100ps
`include "pbc_cfg.svh"

module pbc_regs
(
	// register access
	input  wire logic               CLK_SYS,
	input  wire logic               RST,
	input  wire logic               CE,
	input  wire pbc_pkg::pbc_req_t  REQ,
	output logic [15:0]             RDATA,
	// strap levels
	input  wire logic               STRAP_SPEED,
	input  wire logic               NEGOTIATION_ENABLE_STRAP_PIN,
	input  wire logic               STRAP_ISOLATE,
	input  wire logic               STRAP_DUPLEX,
	// control outputs
	output pbc_pkg::pbc_ctrl_t      CTRL,
	output logic                    CHIP_RESET,
	output logic                    NEG_RESTART,
	output logic                    EFF_SPEED_100,
	output logic                    EFF_FULL_DUPLEX,
	// negotiation outcome
	input  wire logic               NEG_SPEED_100,
	input  wire logic               NEG_FULL_DUPLEX
);

	// ==========================================================
	// state
	pbc_pkg::pbc_ctrl_t  ctrl_reg;
	pbc_pkg::pbc_state_t state_reg;
	logic [3:0]          cnt_reg;
	logic                restart_reg;
	logic                wr_ctrl;
	logic                rst_wr;
	logic                run;
	logic                pd_wake;
	logic                wr_norm;

	function automatic logic hit(input pbc_pkg::pbc_req_t r, input logic [4:0] a);
		hit = r.addr == a;
	endfunction : hit

	// ==========================================================
	// control register word as the host reads it back
	function automatic logic [15:0] ctrl_word
	(
		input pbc_pkg::pbc_ctrl_t c,
		input logic               busy,
		input logic               restart
	);
		logic [15:0] w;
		w                    = `PBC_ZERO16;
		w[`PBC_BIT_RESET]    = busy;
		w[`PBC_BIT_LOOPBACK] = c.loopback;
		w[`PBC_BIT_SPEED]    = c.speed_100;
		w[`PBC_BIT_NEG_EN]   = c.neg_en;
		w[`PBC_BIT_PWRDN]    = c.power_down;
		w[`PBC_BIT_ISOLATE]  = c.isolate;
		w[`PBC_BIT_RESTART]  = restart;
		w[`PBC_BIT_DUPLEX]   = c.full_duplex;
		w[`PBC_BIT_COLTEST]  = c.col_test;
		ctrl_word = w;
	endfunction : ctrl_word

	// ==========================================================
	// status register word: only the two top capability bits
	function automatic logic [15:0] stat_word();
		logic [15:0] w;
		w                     = `PBC_ZERO16;
		w[`PBC_BIT_CAP_T4]    = 1'b0;
		w[`PBC_BIT_CAP_TX_FD] = 1'b1;
		stat_word = w;
	endfunction : stat_word

	assign wr_ctrl = CE && REQ.wr && hit(REQ, `PBC_ADDR_CTRL);
	assign rst_wr  = wr_ctrl && REQ.wdata[`PBC_BIT_RESET];
	// all control register writes, reset writes included, are refused during chip reset
	assign run     = state_reg == pbc_pkg::PBC_RUN;
	assign pd_wake = rst_wr && run && ctrl_reg.power_down;
	assign wr_norm = wr_ctrl && run && !rst_wr;

	// ==========================================================
	// reset sequencer: chip reset pulse, then strap re-latch
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			state_reg <= pbc_pkg::PBC_RELATCH;
		else if (CE)
		begin
			unique case (state_reg)
				pbc_pkg::PBC_RUN:
					if (rst_wr && !ctrl_reg.power_down)
						state_reg <= pbc_pkg::PBC_RESETTING;
				pbc_pkg::PBC_RESETTING:
					if (cnt_reg == `PBC_RST_LAST_CYC)
						state_reg <= pbc_pkg::PBC_RELATCH;
				pbc_pkg::PBC_RELATCH:
					state_reg <= pbc_pkg::PBC_RUN;
				default:
					state_reg <= pbc_pkg::PBC_RUN;
			endcase
		end
	end

	// ==========================================================
	// reset pulse length counter, loaded when a full reset starts
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			cnt_reg <= `PBC_CNT_ZERO;
		else if (CE)
		begin
			if (run && rst_wr && !ctrl_reg.power_down)
				cnt_reg <= `PBC_RST_PULSE_CYC;
			else if (state_reg == pbc_pkg::PBC_RESETTING && cnt_reg != `PBC_RST_LAST_CYC)
				cnt_reg <= cnt_reg - `PBC_CNT_STEP;
		end
	end

	// ==========================================================
	// control bits
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			ctrl_reg <= '0;
		else if (CE)
		begin
			if (state_reg == pbc_pkg::PBC_RESETTING)
				ctrl_reg <= '0;
			else if (state_reg == pbc_pkg::PBC_RELATCH)
			begin
				ctrl_reg             <= '0;
				ctrl_reg.speed_100   <= STRAP_SPEED;
				ctrl_reg.neg_en      <= NEGOTIATION_ENABLE_STRAP_PIN;
				ctrl_reg.isolate     <= STRAP_ISOLATE;
				ctrl_reg.full_duplex <= !STRAP_DUPLEX;
			end
			else if (pd_wake)
				ctrl_reg.power_down <= 1'b0;
			else if (wr_norm)
			begin
				ctrl_reg.loopback    <= REQ.wdata[`PBC_BIT_LOOPBACK];
				ctrl_reg.speed_100   <= REQ.wdata[`PBC_BIT_SPEED];
				ctrl_reg.neg_en      <= REQ.wdata[`PBC_BIT_NEG_EN];
				ctrl_reg.power_down  <= REQ.wdata[`PBC_BIT_PWRDN];
				ctrl_reg.isolate     <= REQ.wdata[`PBC_BIT_ISOLATE];
				ctrl_reg.full_duplex <= REQ.wdata[`PBC_BIT_DUPLEX];
				ctrl_reg.col_test    <= REQ.wdata[`PBC_BIT_COLTEST];
			end
		end
	end

	// ==========================================================
	// restart negotiation pulse, self-clearing
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			restart_reg <= 1'b0;
		else if (CE)
			restart_reg <= wr_norm && REQ.wdata[`PBC_BIT_RESTART]
				&& REQ.wdata[`PBC_BIT_NEG_EN];
	end

	// ==========================================================
	// read data
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			RDATA <= `PBC_ZERO16;
		else if (CE && REQ.rd)
		begin
			if (hit(REQ, `PBC_ADDR_CTRL))
				RDATA <= ctrl_word(ctrl_reg, !run, restart_reg);
			else if (hit(REQ, `PBC_ADDR_STAT))
				RDATA <= stat_word();
			else
				RDATA <= `PBC_ZERO16;
		end
	end

	// ==========================================================
	// outputs
	assign CTRL            = ctrl_reg;
	assign CHIP_RESET      = !run;
	assign NEG_RESTART     = restart_reg;

	// ==========================================================
	// effective speed and duplex: negotiated result wins while negotiating
	always_comb
	begin
		if (ctrl_reg.neg_en)
		begin
			EFF_SPEED_100   = NEG_SPEED_100;
			EFF_FULL_DUPLEX = NEG_FULL_DUPLEX;
		end
		else
		begin
			EFF_SPEED_100   = ctrl_reg.speed_100;
			EFF_FULL_DUPLEX = ctrl_reg.full_duplex;
		end
	end

endmodule : pbc_regs

// >>> hw/pbc_cfg.svh
// constants for the basic phy control and status register bank
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH
`define PBC_ADDR_CTRL      5'h00
`define PBC_ADDR_STAT      5'h01
`define PBC_BIT_RESET      15
`define PBC_BIT_LOOPBACK   14
`define PBC_BIT_SPEED      13
`define PBC_BIT_NEG_EN     12
`define PBC_BIT_PWRDN      11
`define PBC_BIT_ISOLATE    10
`define PBC_BIT_RESTART    9
`define PBC_BIT_DUPLEX     8
`define PBC_BIT_COLTEST    7
`define PBC_STAT_CAPS      16'h4000
`define PBC_ZERO16         16'h0000
`define PBC_RST_PULSE_CYC  4'h4
`define PBC_RST_LAST_CYC   4'h1
`define PBC_CNT_ZERO       4'h0
`define PBC_CNT_STEP       4'h1
`define PBC_BIT_CAP_T4     15
`define PBC_BIT_CAP_TX_FD  14
`endif

// >>> hw/pbc_pkg.sv
// types for the basic phy control and status register bank
package pbc_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} pbc_req_t;

	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic neg_en;
		logic power_down;
		logic isolate;
		logic full_duplex;
		logic col_test;
	} pbc_ctrl_t;

	typedef enum logic [1:0] {
		PBC_RUN,
		PBC_RESETTING,
		PBC_RELATCH
	} pbc_state_t;
endpackage : pbc_pkg

// >>> tb/pbc_regs_assertions.sv
// assertions on the phy control bank ports
`timescale 1ns/100ps
module pbc_chk
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire pbc_pkg::pbc_req_t REQ,
	input wire logic [15:0] RDATA,
	input wire pbc_pkg::pbc_ctrl_t CTRL,
	input wire logic CHIP_RESET,
	input wire logic NEG_RESTART,
	input wire logic EFF_SPEED_100,
	input wire logic NEG_SPEED_100
);
	logic wn;
	logic ws;
	assign wn = REQ.wr && REQ.addr == 5'h00 && !CHIP_RESET && !REQ.wdata[15];
	assign ws = REQ.wr && REQ.addr == 5'h00 && !CHIP_RESET && REQ.wdata[15];
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	a_stat_caps: assert property (REQ.rd && REQ.addr == 5'h01 |=> RDATA == 16'h4000)
		else $error("status caps");
	a_rsvd_zero: assert property (REQ.rd && REQ.addr == 5'h00 |=> RDATA[6:0] == 7'h00)
		else $error("reserved bits");
	a_loop_write: assert property (wn |=> CTRL.loopback == $past(REQ.wdata[14]))
		else $error("loopback");
	a_col_write: assert property (wn |=> CTRL.col_test == $past(REQ.wdata[7]))
		else $error("collision test");
	a_eff_speed: assert property (EFF_SPEED_100 == (CTRL.neg_en ? NEG_SPEED_100 : CTRL.speed_100))
		else $error("speed select");
	a_restart_pulse: assert property (wn && REQ.wdata[12] && REQ.wdata[9] |=> NEG_RESTART ##1 !NEG_RESTART)
		else $error("restart");
	a_soft_reset: assert property (ws && !CTRL.power_down |=> CHIP_RESET [*5] ##1 !CHIP_RESET)
		else $error("soft reset");
	a_pd_wake: assert property (ws && CTRL.power_down |=> !CHIP_RESET && !CTRL.power_down)
		else $error("power-down exit");
endmodule : pbc_chk
bind pbc_regs pbc_chk pbc_chk_i (.CLK_SYS, .RST, .REQ, .RDATA, .CTRL, .CHIP_RESET,
	.NEG_RESTART, .EFF_SPEED_100, .NEG_SPEED_100);

// >>> tb/pbc_host.sv
// management host model issuing register requests
`timescale 1ns/100ps
module pbc_host
(
	input wire logic CLK_SYS,
	output pbc_pkg::pbc_req_t REQ
);
	initial REQ = '0;
	task xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge CLK_SYS);
		REQ <= '{w, !w, a, d};
		@(posedge CLK_SYS);
		REQ <= '0;
	endtask : xfer
endmodule : pbc_host

// >>> tb/tb.sv
// testbench for the phy control and status bank
`timescale 1ns/100ps
module tb;
	logic CLK_SYS = 0, RST = 1, NEG_SPEED_100 = 1, NEG_FULL_DUPLEX = 0;
	logic [3:0] strap = 4'b1011; // speed, negotiation, isolate, duplex
	pbc_pkg::pbc_req_t REQ;
	pbc_pkg::pbc_ctrl_t CTRL;
	logic [15:0] RDATA;
	logic CHIP_RESET, NEG_RESTART, EFF_SPEED_100, EFF_FULL_DUPLEX;
	int err_count = 0, cmp_count = 0;
	always #5 CLK_SYS = !CLK_SYS;
	pbc_host pbc_host_i (.CLK_SYS, .REQ);
	pbc_regs pbc_regs_i (.CLK_SYS, .RST, .CE(1'b1), .REQ, .RDATA, .STRAP_SPEED(strap[3]),
		.NEGOTIATION_ENABLE_STRAP_PIN(strap[2]), .STRAP_ISOLATE(strap[1]),
		.STRAP_DUPLEX(strap[0]), .CTRL, .CHIP_RESET, .NEG_RESTART, .EFF_SPEED_100,
		.EFF_FULL_DUPLEX, .NEG_SPEED_100, .NEG_FULL_DUPLEX);
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task rd(input logic [4:0] a, input logic [15:0] e);
		pbc_host_i.xfer(1'b0, a, 16'h0000);
		#1 chk("RDATA", e, RDATA);
	endtask : rd
	task print_verdict;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task wait_rst;
		#1;
		for (int i = 0; i < 20 && CHIP_RESET !== 1'b0; i++)
			@(negedge CLK_SYS);
		if (CHIP_RESET !== 1'b0)
		begin
			err_count++;
			print_verdict;
		end
	endtask : wait_rst
	initial
	begin
		repeat (16) @(posedge CLK_SYS);
		RST <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		rd(5'h00, 16'h2400);
		pbc_host_i.xfer(1'b1, 5'h01, 16'hffff);
		rd(5'h01, 16'h4000);
		pbc_host_i.xfer(1'b1, 5'h00, 16'h43ff);
		rd(5'h00, 16'h4180);
		chk("EFF", 16'h0001, {14'h0000, EFF_SPEED_100, EFF_FULL_DUPLEX});
		pbc_host_i.xfer(1'b1, 5'h00, 16'h1200);
		#1 chk("RESTART", 16'h0001, {15'h0000, NEG_RESTART});
		chk("EFF", 16'h0002, {14'h0000, EFF_SPEED_100, EFF_FULL_DUPLEX});
		rd(5'h00, 16'h1000);
		pbc_host_i.xfer(1'b1, 5'h00, 16'h0800);
		rd(5'h00, 16'h0800);
		@(posedge CLK_SYS) strap <= 4'b0100;
		pbc_host_i.xfer(1'b1, 5'h00, 16'h8000);
		rd(5'h00, 16'h0000);
		pbc_host_i.xfer(1'b1, 5'h00, 16'h8000);
		wait_rst;
		rd(5'h00, 16'h1100);
		print_verdict;
	end
endmodule : tb
